// *** hdl/srs_supervisor.sv ***
// Supply reset supervisor: reset, sleep, mode matrix, register_a and Avalon-MM registers
`timescale 1ns/1ps

// Functional notes
// [RULE1] Hold internal logic in reset while logic, analog or reference supply is low.
// [RULE2] Missing reference clock forces reset only with the clock watchdog enabled.
// [RULE3] Leave reset a fixed delay after supplies good; host waits that long.
// [RULE4] Power-on reset delay is at most 2.1 ms.
// [RULE5] Absent reference clock is detected within 10 microseconds.
// [RULE6] Set the reset-occurred flag in register_a on every reset exit.
// [RULE7] Any access to register_a clears the reset-occurred flag.
// [RULE8] Pump undervoltage disables the outputs and sets its flag.
// [RULE9] Pump warning sets its own flag; operation otherwise continues normally.
// [RULE10] Enter sleep whenever any monitored supply is below threshold; here a low host I/O supply does not cause sleep.
// [RULE11] Leave sleep once all monitored supplies are good again.
// [RULE12] Watchdog fault: report it, channels and diagnostics off, answer identification only.
// [RULE13] Host I/O supply absent: channels run, writes taken, reads return zero.
// [RULE14] Output enable low: channels and load diagnostics off, interface still works.
// [RULE15] Output enable low drives fault pin low only if enable fault mask set.
// [RULE16] Load supply undervoltage disables only that channel.
// [RULE17] Load supply undervoltage drives fault pin low only if that channel mask set.
// [RULE18] Battery overvoltage disables all channels and drives the fault pin low; while output enable is low the pin follows the enable fault mask instead.
// [RULE19] Fault pin low in reset, sleep, external reset, watchdog fault; else high when good.
module srs_supervisor
  import srs_pkg::*;
#(
  parameter int                  POR_CYCLES  = SRS_POR_CYCLES,
  parameter int                  MISS_CYCLES = SRS_MISS_CYCLES,
  // Arbitrary neutral value
  parameter logic [SRS_DATA_W-1:0] IDENT_WORD = 32'h0000_5A01
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  // Supplies and comparators
  input  wire srs_supply_s             i_supply_ok,
  input  wire logic                    i_pump_uv,
  input  wire logic                    i_pump_warn,
  input  wire logic                    i_bat_ov,
  input  wire logic [SRS_CHANNELS-1:0] i_load_uv,
  // Control pins
  input  wire logic                    i_external_reset_pin_n,
  input  wire logic                    i_clock_watchdog_enable_pin,
  input  wire logic                    i_output_enable,
  input  wire logic                    i_ref_clk,
  // Avalon-MM slave
  input  wire logic [SRS_ADDR_W-1:0]   i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [SRS_DATA_W-1:0]   i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic [SRS_DATA_W-1:0]        o_avs_readdata,
  output logic                         o_avs_waitrequest,
  // Device state
  output logic                         o_in_reset,
  output logic                         o_sleep,
  output logic                         o_watchdog_fault,
  output logic [SRS_CHANNELS-1:0]      o_channel_enable,
  output logic                         o_diag_enable,
  output srs_resp_e                    o_resp_mode,
  output logic                         o_fault_output_pin_n,
  output logic                         o_irq
);

  localparam int POR_W  = $clog2(POR_CYCLES + 1);
  localparam int MISS_W = $clog2(MISS_CYCLES + 1);
  localparam logic [POR_W-1:0]  POR_LAST  = POR_W'(POR_CYCLES - 1);
  localparam logic [MISS_W-1:0] MISS_LAST = MISS_W'(MISS_CYCLES - 2);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [POR_W-1:0]       por_cnt_reg;
  logic [POR_W-1:0]       por_cnt_next;
  logic                   in_reset_reg;
  logic                   in_reset_next;
  logic                   ref_prev_reg;
  logic [MISS_W-1:0]      miss_cnt_reg;
  logic [MISS_W-1:0]      miss_cnt_next;
  logic                   clk_missing_reg;
  srs_diag_s              diag_reg;
  srs_diag_s              diag_next;
  srs_diag_s              mask_reg;
  srs_diag_s              mask_next;
  srs_ctrl_s              ctrl_reg;
  srs_ctrl_s              ctrl_next;
  logic                   wait_reg;
  logic [SRS_DATA_W-1:0]  rdata_reg;
  logic [SRS_DATA_W-1:0]  rdata_next;
  logic                   sleep_reg;
  logic                   wd_fault_reg;
  logic [SRS_CHANNELS-1:0] ch_en_reg;
  logic [SRS_CHANNELS-1:0] ch_en_next;
  logic                   diag_en_reg;
  srs_resp_e              resp_reg;
  srs_resp_e              resp_next;
  logic                   fault_n_reg;
  logic                   fault_n_next;
  logic                   irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Supply, clock watchdog and reset hold
  wire core_uv      = ~i_supply_ok.logic_supply | ~i_supply_ok.analog_supply
                      | ~i_supply_ok.reference_supply;
  wire ref_edge     = i_ref_clk ^ ref_prev_reg;
  wire wd_fault_now = i_clock_watchdog_enable_pin & clk_missing_reg & ~core_uv
                      & i_external_reset_pin_n;
  wire hold_reset   = core_uv | ~i_external_reset_pin_n                      // RULE1
                      | (i_clock_watchdog_enable_pin & clk_missing_reg);    // RULE2
  wire por_done     = (por_cnt_reg == POR_LAST);
  wire reset_exit   = in_reset_reg & ~in_reset_next;

  assign miss_cnt_next = ref_edge ? '0 :
                         (miss_cnt_reg == MISS_LAST) ? miss_cnt_reg : miss_cnt_reg + 1'b1;
  assign por_cnt_next  = hold_reset ? '0 :
                         por_done   ? por_cnt_reg : por_cnt_reg + 1'b1;    // RULE3 RULE4
  assign in_reset_next = hold_reset | (in_reset_reg & ~por_done);          // RULE3

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ref_prev_reg    <= 1'b0;
      miss_cnt_reg    <= '0;
      clk_missing_reg <= 1'b1;
    end else begin
      ref_prev_reg    <= i_ref_clk;
      miss_cnt_reg    <= miss_cnt_next;
      clk_missing_reg <= (miss_cnt_next == MISS_LAST);                      // RULE5
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      por_cnt_reg  <= '0;
      in_reset_reg <= 1'b1;
    end else begin
      por_cnt_reg  <= por_cnt_next;
      in_reset_reg <= in_reset_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, access completes on the second edge
  wire       req        = i_avs_read | i_avs_write;
  wire       accept     = req & ~wait_reg;
  wire       wr_accept  = accept & i_avs_write;
  wire       rd_accept  = accept & i_avs_read;
  wire       sel_a      = (i_avs_address == SRS_REG_A_OFS);
  wire       sel_mask   = (i_avs_address == SRS_IRQ_MASK_OFS);
  wire       sel_ctrl   = (i_avs_address == SRS_CONTROL_OFS);
  wire       sel_live   = (i_avs_address == SRS_LIVE_OFS);
  wire       sel_ident  = (i_avs_address == SRS_IDENT_OFS);
  wire       wr_allowed = (resp_reg == SRS_RESP_NORMAL) | (resp_reg == SRS_RESP_ZERO);  // RULE13
  wire       wr_lane0   = wr_accept & wr_allowed & i_avs_byteenable[0];
  srs_live_s live;

  assign live.clock_missing  = clk_missing_reg;
  assign live.watchdog_fault = wd_fault_reg;
  assign live.sleep          = sleep_reg;
  assign live.in_reset       = in_reset_reg;

  wire [SRS_DATA_W-1:0] reg_word =
    sel_a     ? SRS_DATA_W'(diag_reg) :
    sel_mask  ? SRS_DATA_W'(mask_reg) :
    sel_ctrl  ? SRS_DATA_W'(ctrl_reg) :
    sel_live  ? SRS_DATA_W'(live)     :
    sel_ident ? IDENT_WORD            : '0;

  // Identification only under watchdog fault, zeros while host I/O is absent or in reset
  assign rdata_next = (resp_reg == SRS_RESP_IDENT)  ? IDENT_WORD :          // RULE12
                      (resp_reg == SRS_RESP_NORMAL) ? reg_word   : '0;      // RULE13

  assign mask_next = (wr_lane0 & sel_mask) ? srs_diag_s'(i_avs_writedata[SRS_DIAG_W-1:0]) : mask_reg;
  assign ctrl_next = (wr_lane0 & sel_ctrl) ? srs_ctrl_s'(i_avs_writedata[SRS_CTRL_W-1:0]) : ctrl_reg;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= '0;
    end else begin
      wait_reg  <= ~(req & wait_reg);
      rdata_reg <= (req & wait_reg) ? rdata_next : rdata_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || in_reset_reg) begin
      mask_reg <= SRS_DIAG_RST;
      ctrl_reg <= SRS_CTRL_RST;
    end else begin
      mask_reg <= mask_next;
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register_a flags: sticky, a read in normal response mode clears them and any access clears reset_seen, a new event in the same cycle wins
  wire       a_access = accept & sel_a;
  wire       a_read   = rd_accept & sel_a & (resp_reg == SRS_RESP_NORMAL);
  srs_diag_s events;
  srs_diag_s kept;

  assign events.wd_fault               = wd_fault_now;
  assign events.bat_ov                 = i_bat_ov & ~in_reset_reg;
  assign events.load_uv                = i_load_uv & {SRS_CHANNELS{~in_reset_reg}};
  assign events.pump_warning_flag      = i_pump_warn & ~in_reset_reg;       // RULE9
  assign events.pump_undervoltage_flag = i_pump_uv & ~in_reset_reg;         // RULE8
  assign events.reset_seen             = reset_exit;                        // RULE6

  assign kept.wd_fault               = diag_reg.wd_fault & ~a_read;
  assign kept.bat_ov                 = diag_reg.bat_ov & ~a_read;
  assign kept.load_uv                = diag_reg.load_uv & {SRS_CHANNELS{~a_read}};
  assign kept.pump_warning_flag      = diag_reg.pump_warning_flag & ~a_read;
  assign kept.pump_undervoltage_flag = diag_reg.pump_undervoltage_flag & ~a_read;
  assign kept.reset_seen             = diag_reg.reset_seen & ~a_access;     // RULE7

  assign diag_next = events | kept;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      diag_reg <= SRS_DIAG_RST;
      irq_reg  <= 1'b0;
    end else begin
      diag_reg <= diag_next;
      irq_reg  <= |(diag_next & mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode matrix
  wire any_load_masked = |(i_load_uv & ctrl_reg.channel_fault_mask);
  wire run_common      = ~in_reset_next & i_output_enable                   // RULE14
                         & ~i_pump_uv & ~i_bat_ov;                          // RULE8 RULE18

  genvar ch;
  generate
    for (ch = 0; ch < SRS_CHANNELS; ch++) begin : g_ch
      assign ch_en_next[ch] = run_common & ~i_load_uv[ch];                 // RULE16
    end
  endgenerate

  assign resp_next = wd_fault_now                  ? SRS_RESP_IDENT :      // RULE12
                     in_reset_next                 ? SRS_RESP_HOLD  :      // RULE3
                     ~i_supply_ok.host_io_supply   ? SRS_RESP_ZERO  :      // RULE13
                                                     SRS_RESP_NORMAL;

  assign fault_n_next = in_reset_next | core_uv | wd_fault_now ? 1'b0 :    // RULE19
                        ~i_output_enable ? ~ctrl_reg.enable_fault_mask :   // RULE15
                        (i_pump_uv | i_bat_ov) ? 1'b0 :                    // RULE18
                        ~any_load_masked;                                  // RULE17

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sleep_reg    <= 1'b1;
      wd_fault_reg <= 1'b0;
      ch_en_reg    <= '0;
      diag_en_reg  <= 1'b0;
      resp_reg     <= SRS_RESP_HOLD;
      fault_n_reg  <= 1'b0;
    end else begin
      sleep_reg    <= core_uv;                                             // RULE10 RULE11
      wd_fault_reg <= wd_fault_now;
      ch_en_reg    <= ch_en_next;
      diag_en_reg  <= ~in_reset_next & i_output_enable;                    // RULE14
      resp_reg     <= resp_next;
      fault_n_reg  <= fault_n_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_avs_readdata       = rdata_reg;
  assign o_avs_waitrequest    = wait_reg;
  assign o_in_reset           = in_reset_reg;
  assign o_sleep              = sleep_reg;
  assign o_watchdog_fault     = wd_fault_reg;
  assign o_channel_enable     = ch_en_reg;
  assign o_diag_enable        = diag_en_reg;
  assign o_resp_mode          = resp_reg;
  assign o_fault_output_pin_n = fault_n_reg;
  assign o_irq                = irq_reg;

endmodule

// *** hdl/srs_pkg.sv ***
// Constants, register map and carrier types of the supply reset supervisor
package srs_pkg;

  // Clock and timing
  localparam real SRS_CLK_MHZ          = 100.0;
  localparam real SRS_POR_TIME_MS      = 2.1;
  localparam real SRS_MISS_TIME_US     = 10.0;
  localparam int  SRS_POR_CYCLES       = $rtoi(SRS_POR_TIME_MS * 1000.0 * SRS_CLK_MHZ);
  localparam int  SRS_MISS_CYCLES      = $rtoi(SRS_MISS_TIME_US * SRS_CLK_MHZ);

  // Structure
  localparam int  SRS_CHANNELS         = 2;
  localparam int  SRS_ADDR_W           = 5;
  localparam int  SRS_DATA_W           = 32;

  // Register byte addresses
  localparam logic [SRS_ADDR_W-1:0] SRS_REG_A_OFS     = 5'h00;
  localparam logic [SRS_ADDR_W-1:0] SRS_IRQ_MASK_OFS  = 5'h04;
  localparam logic [SRS_ADDR_W-1:0] SRS_CONTROL_OFS   = 5'h08;
  localparam logic [SRS_ADDR_W-1:0] SRS_LIVE_OFS      = 5'h0C;
  localparam logic [SRS_ADDR_W-1:0] SRS_IDENT_OFS     = 5'h10;

  // Avalon-MM response modes
  typedef enum logic [1:0] {
    SRS_RESP_NORMAL,
    SRS_RESP_IDENT,
    SRS_RESP_ZERO,
    SRS_RESP_HOLD
  } srs_resp_e;

  // Register_a register layout, also the interrupt mask layout
  typedef struct packed {
    logic                    wd_fault;
    logic                    bat_ov;
    logic [SRS_CHANNELS-1:0] load_uv;
    logic                    pump_warning_flag;
    logic                    pump_undervoltage_flag;
    logic                    reset_seen;
  } srs_diag_s;

  localparam int SRS_DIAG_W = $bits(srs_diag_s);

  // Control register layout
  typedef struct packed {
    logic [SRS_CHANNELS-1:0] channel_fault_mask;
    logic                    enable_fault_mask;
  } srs_ctrl_s;

  localparam int SRS_CTRL_W = $bits(srs_ctrl_s);

  // Live state, read-only
  typedef struct packed {
    logic clock_missing;
    logic watchdog_fault;
    logic sleep;
    logic in_reset;
  } srs_live_s;

  localparam int SRS_LIVE_W = $bits(srs_live_s);

  // Monitored supply comparator levels, high when above threshold
  typedef struct packed {
    logic logic_supply;
    logic analog_supply;
    logic reference_supply;
    logic host_io_supply;
  } srs_supply_s;

  localparam srs_diag_s SRS_DIAG_RST = '0;
  localparam srs_ctrl_s SRS_CTRL_RST = '0;

endpackage

// *** verification/srs_host_model.sv ***
// Host side model: drives the reference clock toward the supervisor
`timescale 1ns/1ps
module srs_host_model (
  // Clock and control
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_run,
  // Reference clock, stands still while not running
  output logic      o_ref_clk
);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ref_clk <= 1'h0;
    end else if (i_run) begin
      o_ref_clk <= ~o_ref_clk;
    end
  end
endmodule

// *** verification/srs_supervisor_props.sv ***
// Port level checker of the supply reset supervisor
`timescale 1ns/1ps
module srs_supervisor_props
  import srs_pkg::*;
#(
  parameter int POR_CYCLES  = 20,
  parameter int MISS_CYCLES = 10
) (
  // Clock, reset and inputs
  input wire logic                    i_clk,
  input wire logic                    i_sys_rst,
  input wire srs_supply_s             i_supply_ok,
  input wire logic                    i_pump_uv,
  input wire logic                    i_bat_ov,
  input wire logic [SRS_CHANNELS-1:0] i_load_uv,
  input wire logic                    i_external_reset_pin_n,
  input wire logic                    i_clock_watchdog_enable_pin,
  input wire logic                    i_output_enable,
  input wire logic                    i_ref_clk,
  // Outputs
  input wire logic                    o_in_reset,
  input wire logic                    o_sleep,
  input wire logic                    o_watchdog_fault,
  input wire logic [SRS_CHANNELS-1:0] o_channel_enable,
  input wire logic                    o_diag_enable,
  input wire srs_resp_e               o_resp_mode,
  input wire logic                    o_fault_output_pin_n
);
  wire logic   core_ok = &i_supply_ok[3:1];
  logic [31:0] good_cnt;
  logic [31:0] miss_cnt;
  logic        ref_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////////
  // Cycles free of reset sources with the clock watchdog pin low, and cycles since a reference edge
  always_ff @(posedge i_clk) begin
    ref_q    <= i_ref_clk;
    good_cnt <= (i_sys_rst || !core_ok || !i_external_reset_pin_n || i_clock_watchdog_enable_pin) ? '0 : good_cnt + 1;
    miss_cnt <= (i_sys_rst || i_ref_clk != ref_q) ? '0 : miss_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////
  core_uv_hold_a: assert property (!core_ok |=> o_in_reset) else $error("reset not held on supply low");
  sleep_entry_a: assert property (!core_ok && !$past(i_sys_rst) |=> o_sleep) else $error("no sleep");
  sleep_exit_a: assert property (core_ok && !$past(i_sys_rst) |=> !o_sleep) else $error("sleep kept");
  por_min_a: assert property ($fell(o_in_reset) && !i_clock_watchdog_enable_pin |-> good_cnt >= POR_CYCLES)
    else $error("reset left too early");
  por_max_a: assert property (good_cnt == POR_CYCLES + 3 |-> !o_in_reset) else $error("reset left late");
  miss_detect_a: assert property (miss_cnt >= MISS_CYCLES + 2 && i_clock_watchdog_enable_pin && core_ok
    && i_external_reset_pin_n |=> o_watchdog_fault) else $error("missing clock not seen");
  wd_fault_mode_a: assert property (o_watchdog_fault |-> o_in_reset && o_channel_enable == '0 && !o_diag_enable
    && o_resp_mode == SRS_RESP_IDENT) else $error("watchdog mode wrong");
  oe_off_a: assert property (!i_output_enable |=> o_channel_enable == '0 && !o_diag_enable) else $error("oe ignored");
  pump_bat_off_a: assert property (i_pump_uv || i_bat_ov |=> o_channel_enable == '0 && !o_fault_output_pin_n)
    else $error("outputs not disabled");
  load_uv_one_a: assert property (i_load_uv == 2'h1 && i_output_enable && !i_pump_uv && !i_bat_ov ##1 !o_in_reset
    |-> o_channel_enable == 2'h2) else $error("load undervoltage channel wrong");
  fault_low_a: assert property (o_in_reset || o_sleep |-> !o_fault_output_pin_n) else $error("fault pin high");
endmodule
bind srs_supervisor srs_supervisor_props #(.POR_CYCLES(POR_CYCLES), .MISS_CYCLES(MISS_CYCLES)) i_srs_supervisor_props (.*);

// *** verification/srs_supervisor_bench.sv ***
// Self-checking bench of the supply reset supervisor
`timescale 1ns/1ps
module srs_supervisor_bench;
  import srs_pkg::*;
  localparam int POR = 20;
  localparam int MISS = 10;
  // Arbitrary neutral value
  localparam logic [31:0] IDENT = 32'h0000_5A01;
  logic        i_clk = 1'h0, i_sys_rst = 1'h1, pump_uv = 1'h0, pump_warn = 1'h0, bat_ov = 1'h0;
  logic        external_reset_pin = 1'h1, clock_watchdog_enable_pin = 1'h0, oe = 1'h1, run = 1'h1, rd = 1'h0, wr = 1'h0;
  srs_supply_s sup = 4'hF;
  logic [1:0]  load_uv = 2'h0;
  logic [4:0]  adr = 5'h00;
  logic [3:0]  be = 4'hF;
  logic [31:0] wdat = 32'h0, q;
  wire logic   ref_clk, waitreq, in_reset, sleep, wd_fault, diag_en, fault_n, irq;
  wire logic [1:0] ch_en;
  wire logic [31:0] rdata;
  wire srs_resp_e  resp;
  int          miscompares = 0, n_compared = 0, cyc_cnt = 0, n;
  srs_host_model i_srs_host_model (.i_clk(i_clk), .i_rst(i_sys_rst), .i_run(run), .o_ref_clk(ref_clk));
  srs_supervisor #(.POR_CYCLES(POR), .MISS_CYCLES(MISS), .IDENT_WORD(IDENT)) i_srs_supervisor (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_supply_ok(sup), .i_pump_uv(pump_uv), .i_pump_warn(pump_warn),
    .i_bat_ov(bat_ov), .i_load_uv(load_uv), .i_external_reset_pin_n(external_reset_pin), .i_clock_watchdog_enable_pin(clock_watchdog_enable_pin),
    .i_output_enable(oe), .i_ref_clk(ref_clk), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .o_in_reset(in_reset), .o_sleep(sleep), .o_watchdog_fault(wd_fault), .o_channel_enable(ch_en),
    .o_diag_enable(diag_en), .o_resp_mode(resp), .o_fault_output_pin_n(fault_n), .o_irq(irq));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge i_clk);
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge i_clk); while (waitreq !== 1'h0);
    q = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
    // Let one edge pass so a following call never reassigns rd or wr in this time step
    @(posedge i_clk);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wait_out();
    n = 0;
    while (in_reset !== 1'h0 && n < 200) begin
      @(posedge i_clk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_por();
    wait_out();
    chk(32'(n >= POR && n <= POR + 3), 32'h1);
    rdchk(SRS_LIVE_OFS, 32'h0);
    rdchk(SRS_REG_A_OFS, 32'h1);
    rdchk(SRS_REG_A_OFS, 32'h0);
    rdchk(5'h1C, 32'h0);
  endtask
  task automatic t_pump();
    pump_warn <= 1'h1;
    cyc(3);
    chk(32'(ch_en), 32'h3);
    pump_uv <= 1'h1;
    cyc(3);
    chk(32'({ch_en, fault_n}), 32'h0);
    pump_uv <= 1'h0;
    pump_warn <= 1'h0;
    cyc(2);
    rdchk(SRS_REG_A_OFS, 32'h6);
    bus(1'h1, SRS_IRQ_MASK_OFS, 32'h2);
    pump_uv <= 1'h1;
    cyc(2);
    pump_uv <= 1'h0;
    cyc(2);
    chk(32'(irq), 32'h1);
    rdchk(SRS_REG_A_OFS, 32'h2);
    cyc(2);
    chk(32'(irq), 32'h0);
    bus(1'h1, SRS_IRQ_MASK_OFS, 32'h0);
    pump_uv <= 1'h1;
    cyc(2);
    pump_uv <= 1'h0;
    cyc(2);
    chk(32'(irq), 32'h0);
    rdchk(SRS_REG_A_OFS, 32'h2);
  endtask
  task automatic t_oe();
    bus(1'h1, SRS_CONTROL_OFS, 32'h1);
    oe <= 1'h0;
    cyc(3);
    chk(32'({ch_en, diag_en, fault_n}), 32'h0);
    bus(1'h1, SRS_CONTROL_OFS, 32'h0);
    cyc(2);
    chk(32'(fault_n), 32'h1);
    rdchk(SRS_CONTROL_OFS, 32'h0);
    oe <= 1'h1;
  endtask
  task automatic t_load();
    bus(1'h1, SRS_CONTROL_OFS, 32'h2);
    load_uv <= 2'h1;
    cyc(3);
    chk(32'({ch_en, fault_n}), 32'h4);
    bus(1'h1, SRS_CONTROL_OFS, 32'h4);
    cyc(2);
    chk(32'({ch_en, fault_n}), 32'h5);
    load_uv <= 2'h0;
    bat_ov <= 1'h1;
    cyc(3);
    chk(32'({ch_en, fault_n}), 32'h0);
    bat_ov <= 1'h0;
    cyc(2);
    rdchk(SRS_REG_A_OFS, 32'h28);
  endtask
  task automatic t_supply();
    sup <= 4'hE;
    cyc(3);
    chk(32'({ch_en, resp}), 32'({2'h3, SRS_RESP_ZERO}));
    rdchk(SRS_IDENT_OFS, 32'h0);
    sup <= 4'h7;
    cyc(3);
    chk(32'({sleep, in_reset, fault_n}), 32'h6);
    sup <= 4'hF;
    cyc(3);
    chk(32'(sleep), 32'h0);
    wait_out();
    // Mask is cleared while in reset, so it is set only after the exit
    bus(1'h1, SRS_IRQ_MASK_OFS, 32'h1);
    cyc(1);
    chk(32'(irq), 32'h1);
    bus(1'h1, SRS_REG_A_OFS, 32'h0);
    rdchk(SRS_REG_A_OFS, 32'h0);
  endtask
  task automatic t_external_reset_pin();
    external_reset_pin <= 1'h0;
    cyc(3);
    chk(32'({in_reset, sleep, fault_n}), 32'h4);
    external_reset_pin <= 1'h1;
    wait_out();
    chk(32'(n >= POR && n <= POR + 3), 32'h1);
    rdchk(SRS_REG_A_OFS, 32'h1);
  endtask
  task automatic t_wd();
    run <= 1'h0;
    cyc(MISS + 5);
    chk(32'(in_reset), 32'h0);
    clock_watchdog_enable_pin <= 1'h1;
    n = 0;
    while (wd_fault !== 1'h1 && n < 40) begin
      @(posedge i_clk);
      n++;
    end
    chk(32'(n <= 2), 32'h1);
    rdchk(SRS_REG_A_OFS, IDENT);
    run <= 1'h1;
    wait_out();
    rdchk(SRS_REG_A_OFS, 32'h41);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    t_por();
    t_pump();
    t_oe();
    t_load();
    t_supply();
    t_external_reset_pin();
    t_wd();
    stop_test();
  end
endmodule
